// >>> hw/multifunction_pin_allocator.sv
module multifunction_pin_allocator
  import pin_alloc_pkg::*;
(
  input  wire logic                    clock,
  input  wire logic                    nrst,
  input  wire pin_alloc_pkg::pin_cfg_s cfg_in,
  input  wire logic                    cfg_write,
  input  wire logic                    regulator_select_pin,
  input  wire logic                    protocol_select_pin,
  input  wire logic                    mclk_pin,
  input  wire logic                    bclk_pin_in,
  input  wire logic                    wclk_pin_in,
  input  wire logic                    din_pin,
  input  wire logic                    gpio_pin_in,
  input  wire logic                    sclk_pin,
  input  wire pin_alloc_pkg::core_out_s core_out,
  output logic                         bclk_pin_out,
  output logic                         bclk_pin_oe_n,
  output logic                         wclk_pin_out,
  output logic                         wclk_pin_oe_n,
  output logic                         gpio_pin_out,
  output logic                         gpio_pin_oe_n,
  output logic                         dout_pin_out,
  output logic                         dout_pin_oe_n,
  output pin_alloc_pkg::core_in_s      core_in,
  output pin_alloc_pkg::pin_cfg_s      cfg_state,
  output logic                         control_four_wire,
  output logic                         regulator_enable
);
  import pin_alloc_pkg::*;

  pin_cfg_s               cfg_reg;
  pin_cfg_s               cfg_next;
  logic [NUM_IN_PINS-1:0] pin_raw;
  logic [NUM_IN_PINS-1:0] pin_s;
  core_in_s               core_in_next;
  logic                   gpio_drv;
  logic                   gpio_val;
  logic                   dout_drv;
  logic                   dout_val;
  logic                   regulator_sync_reg;

  // Clears the other function of an exclusive pin that the reference source takes
  function automatic pin_cfg_s legalise(input pin_cfg_s c);
    pin_cfg_s r;
    r = c;
    if (r.ref_src == REF_DIN) begin
      r.din_is_gpi = 1'b0;
    end
    if (r.ref_src == REF_GPIO) begin
      r.gpio_fn = GPIO_FN_OFF;
    end
    if (r.ref_src == REF_BCLK) begin
      r.bclk_is_out = 1'b0;
    end
    if (r.sec_sig > SEC_SIG_DIN) begin
      r.sec_sig = SEC_SIG_BCLK;
    end
    return r;
  endfunction

  // Gates a pin level onto an input function only while allocated
  function automatic logic route_in(input logic allocated, input logic level);
    return allocated & level;
  endfunction

  assign pin_raw = {protocol_select_pin, sclk_pin, gpio_pin_in, din_pin,
                    wclk_pin_in, bclk_pin_in, mclk_pin};

  pin_sync u_sync (
    .clock        (clock),
    .nrst         (nrst),
    .pin_async    (pin_raw),
    .pin_sync_out (pin_s)
  );

  always_comb begin
    cfg_next = cfg_reg;
    if (cfg_write) begin
      cfg_next = legalise(cfg_in);
    end
  end

  // Configuration
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cfg_reg <= CFG_RESET;
    end else begin
      cfg_reg <= cfg_next;
    end
  end

  // Fixed-function pins are never touched by the configuration
  // The regulator strap is a raw pin too, so it gets its own two-stage synchroniser
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      control_four_wire  <= 1'b0;
      regulator_sync_reg <= 1'b0;
      regulator_enable   <= 1'b0;
    end else begin
      control_four_wire  <= pin_s[PIN_SEL];
      regulator_sync_reg <= regulator_select_pin;
      regulator_enable   <= regulator_sync_reg;
    end
  end

  always_comb begin
    core_in_next = '0;
    // Master clock pin carries the codec clock unless the reference is the bit clock or gpio pin
    core_in_next.codec_clk = pin_s[PIN_MCLK];
    case (cfg_reg.ref_src)
      REF_MCLK: begin
        core_in_next.pll_ref = pin_s[PIN_MCLK];
      end
      REF_BCLK: begin
        core_in_next.pll_ref   = pin_s[PIN_BCLK];
        core_in_next.codec_clk = pin_s[PIN_BCLK];
      end
      REF_DIN: begin
        core_in_next.pll_ref = pin_s[PIN_DIN];
      end
      REF_GPIO: begin
        core_in_next.pll_ref   = pin_s[PIN_GPIO];
        core_in_next.codec_clk = pin_s[PIN_GPIO];
      end
      default: begin
        core_in_next.pll_ref = 1'b0;
      end
    endcase
    core_in_next.bclk = route_in(!cfg_reg.bclk_is_out, pin_s[PIN_BCLK]);
    core_in_next.wclk = route_in(!cfg_reg.wclk_is_out, pin_s[PIN_WCLK]);
    core_in_next.din  = route_in(cfg_reg.ref_src != REF_DIN && !cfg_reg.din_is_gpi,
                                 pin_s[PIN_DIN]);
    core_in_next.gpi1 = route_in(cfg_reg.din_is_gpi, pin_s[PIN_DIN]);
    core_in_next.gpi2 = route_in(cfg_reg.gpio_fn == GPIO_FN_GPI, pin_s[PIN_GPIO]);
    core_in_next.gpi3 = route_in(cfg_reg.sclk_fn == SCLK_FN_GPI, pin_s[PIN_SCLK]);
    // Secondary inputs come from whichever pin is allocated, gpio pin first
    if (cfg_reg.gpio_fn == GPIO_FN_SEC_IN) begin
      core_in_next.sec_bclk = route_in(cfg_reg.sec_sig == SEC_SIG_BCLK, pin_s[PIN_GPIO]);
      core_in_next.sec_wclk = route_in(cfg_reg.sec_sig == SEC_SIG_WCLK, pin_s[PIN_GPIO]);
      core_in_next.sec_din  = route_in(cfg_reg.sec_sig == SEC_SIG_DIN, pin_s[PIN_GPIO]);
    end else if (cfg_reg.sclk_fn == SCLK_FN_SEC_IN) begin
      core_in_next.sec_bclk = route_in(cfg_reg.sec_sig == SEC_SIG_BCLK, pin_s[PIN_SCLK]);
      core_in_next.sec_wclk = route_in(cfg_reg.sec_sig == SEC_SIG_WCLK, pin_s[PIN_SCLK]);
      core_in_next.sec_din  = route_in(cfg_reg.sec_sig == SEC_SIG_DIN, pin_s[PIN_SCLK]);
    end
  end

  // Inputs to the core are registered so they never glitch on a config change
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      core_in <= '0;
    end else begin
      core_in <= core_in_next;
    end
  end

  // Exactly one function per output pin: the case picks a single source
  always_comb begin
    gpio_drv = 1'b1;
    gpio_val = 1'b0;
    case (cfg_reg.gpio_fn)
      GPIO_FN_GPO:       gpio_val = core_out.gpo1;
      GPIO_FN_FIRST_INTERRUPT_OUTPUT:      gpio_val = core_out.first_interrupt_output;
      GPIO_FN_SECOND_INTERRUPT_OUTPUT:      gpio_val = core_out.second_interrupt_output;
      GPIO_FN_SEC_BCLKO: gpio_val = core_out.sec_bclk;
      GPIO_FN_AUX_CLK:   gpio_val = core_out.aux_clk;
      default: begin
        gpio_drv = 1'b0;
      end
    endcase
    dout_drv = 1'b1;
    dout_val = 1'b0;
    case (cfg_reg.dout_fn)
      DOUT_FN_GPO:       dout_val = core_out.gpo2;
      DOUT_FN_FIRST_INTERRUPT_OUTPUT:      dout_val = core_out.first_interrupt_output;
      DOUT_FN_SECOND_INTERRUPT_OUTPUT:      dout_val = core_out.second_interrupt_output;
      DOUT_FN_SEC_BCLKO: dout_val = core_out.sec_bclk;
      DOUT_FN_SEC_WCLKO: dout_val = core_out.sec_wclk;
      DOUT_FN_SEC_DOUT:  dout_val = core_out.sec_dout;
      DOUT_FN_AUX_CLK:   dout_val = core_out.aux_clk;
      default: begin
        dout_drv = 1'b0;
      end
    endcase
  end

  // Pin drivers
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      bclk_pin_out  <= 1'b0;
      bclk_pin_oe_n <= 1'b1;
      wclk_pin_out  <= 1'b0;
      wclk_pin_oe_n <= 1'b1;
      gpio_pin_out  <= 1'b0;
      gpio_pin_oe_n <= 1'b1;
      dout_pin_out  <= 1'b0;
      dout_pin_oe_n <= 1'b1;
    end else begin
      bclk_pin_out  <= cfg_reg.bclk_is_out & core_out.bclk;
      bclk_pin_oe_n <= !cfg_reg.bclk_is_out;
      wclk_pin_out  <= cfg_reg.wclk_is_out & core_out.wclk;
      wclk_pin_oe_n <= !cfg_reg.wclk_is_out;
      gpio_pin_out  <= gpio_val;
      gpio_pin_oe_n <= !gpio_drv;
      dout_pin_out  <= dout_val;
      dout_pin_oe_n <= !dout_drv;
    end
  end

  assign cfg_state = cfg_reg;

endmodule

// >>> hw/pin_alloc_pkg.sv
package pin_alloc_pkg;

  // Reference source for the clock multiplier and the codec clock
  localparam logic [1:0] REF_MCLK = 2'h0;
  localparam logic [1:0] REF_BCLK = 2'h1;
  localparam logic [1:0] REF_DIN  = 2'h2;
  localparam logic [1:0] REF_GPIO = 2'h3;

  // Function codes for the general-purpose pin
  localparam logic [2:0] GPIO_FN_OFF       = 3'h0;
  localparam logic [2:0] GPIO_FN_GPO       = 3'h1;
  localparam logic [2:0] GPIO_FN_GPI       = 3'h2;
  localparam logic [2:0] GPIO_FN_FIRST_INTERRUPT_OUTPUT      = 3'h3;
  localparam logic [2:0] GPIO_FN_SECOND_INTERRUPT_OUTPUT      = 3'h4;
  localparam logic [2:0] GPIO_FN_SEC_IN    = 3'h5;
  localparam logic [2:0] GPIO_FN_SEC_BCLKO = 3'h6;
  localparam logic [2:0] GPIO_FN_AUX_CLK   = 3'h7;

  // Function codes for the serial data out pin
  localparam logic [2:0] DOUT_FN_OFF       = 3'h0;
  localparam logic [2:0] DOUT_FN_GPO       = 3'h1;
  localparam logic [2:0] DOUT_FN_FIRST_INTERRUPT_OUTPUT      = 3'h2;
  localparam logic [2:0] DOUT_FN_SECOND_INTERRUPT_OUTPUT      = 3'h3;
  localparam logic [2:0] DOUT_FN_SEC_BCLKO = 3'h4;
  localparam logic [2:0] DOUT_FN_SEC_WCLKO = 3'h5;
  localparam logic [2:0] DOUT_FN_SEC_DOUT  = 3'h6;
  localparam logic [2:0] DOUT_FN_AUX_CLK   = 3'h7;

  // Function codes for the serial clock pin
  localparam logic [1:0] SCLK_FN_OFF    = 2'h0;
  localparam logic [1:0] SCLK_FN_GPI    = 2'h1;
  localparam logic [1:0] SCLK_FN_SEC_IN = 2'h2;

  // Secondary interface input selector
  localparam logic [1:0] SEC_SIG_BCLK = 2'h0;
  localparam logic [1:0] SEC_SIG_WCLK = 2'h1;
  localparam logic [1:0] SEC_SIG_DIN  = 2'h2;

  localparam int SYNC_STAGES = 2;
  localparam int NUM_IN_PINS = 7;

  // Pin indices inside the synchronised input vector
  localparam int PIN_MCLK = 0;
  localparam int PIN_BCLK = 1;
  localparam int PIN_WCLK = 2;
  localparam int PIN_DIN  = 3;
  localparam int PIN_GPIO = 4;
  localparam int PIN_SCLK = 5;
  localparam int PIN_SEL  = 6;

  typedef struct packed {
    logic [1:0] ref_src;
    logic       bclk_is_out;
    logic       wclk_is_out;
    logic       din_is_gpi;
    logic [2:0] gpio_fn;
    logic [2:0] dout_fn;
    logic [1:0] sclk_fn;
    logic [1:0] sec_sig;
  } pin_cfg_s;

  localparam pin_cfg_s CFG_RESET = '{
    ref_src:     REF_MCLK,
    bclk_is_out: 1'b0,
    wclk_is_out: 1'b0,
    din_is_gpi:  1'b0,
    gpio_fn:     GPIO_FN_OFF,
    dout_fn:     DOUT_FN_OFF,
    sclk_fn:     SCLK_FN_OFF,
    sec_sig:     SEC_SIG_BCLK
  };

  typedef struct packed {
    logic pll_ref;
    logic codec_clk;
    logic bclk;
    logic wclk;
    logic din;
    logic gpi1;
    logic gpi2;
    logic gpi3;
    logic sec_bclk;
    logic sec_wclk;
    logic sec_din;
  } core_in_s;

  typedef struct packed {
    logic bclk;
    logic wclk;
    logic gpo1;
    logic gpo2;
    logic first_interrupt_output;
    logic second_interrupt_output;
    logic sec_bclk;
    logic sec_wclk;
    logic sec_dout;
    logic aux_clk;
  } core_out_s;

endpackage

// >>> hw/pin_sync.sv
module pin_sync
  import pin_alloc_pkg::*;
(
  input  wire logic                   clock,
  input  wire logic                   nrst,
  input  wire logic [NUM_IN_PINS-1:0] pin_async,
  output logic      [NUM_IN_PINS-1:0] pin_sync_out
);

  // First stage feeds only the second stage
  logic [NUM_IN_PINS-1:0] stage_reg [SYNC_STAGES];

  genvar i;
  generate
    for (i = 0; i < NUM_IN_PINS; i++) begin : g_bit
      always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
          stage_reg[0][i] <= 1'b0;
          stage_reg[1][i] <= 1'b0;
        end else begin
          stage_reg[0][i] <= pin_async[i];
          stage_reg[1][i] <= stage_reg[0][i];
        end
      end
    end
  endgenerate

  assign pin_sync_out = stage_reg[SYNC_STAGES-1];

endmodule

// >>> test/pin_alloc_sva.sv
module pin_alloc_sva
  import pin_alloc_pkg::*;
(
  input wire logic                    clock,
  input wire logic                    nrst,
  input wire pin_alloc_pkg::pin_cfg_s cfg_in,
  input wire logic                    cfg_write,
  input wire logic                    regulator_select_pin,
  input wire logic                    protocol_select_pin,
  input wire logic                    bclk_pin_in,
  input wire logic                    din_pin,
  input wire logic                    sclk_pin,
  input wire pin_alloc_pkg::core_out_s core_out,
  input wire logic                    bclk_pin_out,
  input wire logic                    bclk_pin_oe_n,
  input wire logic                    gpio_pin_out,
  input wire logic                    gpio_pin_oe_n,
  input wire logic                    dout_pin_out,
  input wire logic                    dout_pin_oe_n,
  input wire pin_alloc_pkg::core_in_s core_in,
  input wire pin_alloc_pkg::pin_cfg_s cfg_state,
  input wire logic                    control_four_wire,
  input wire logic                    regulator_enable
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] up_cnt_reg;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);

  // Pin history before release is not trusted until the sync chain has refilled
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) up_cnt_reg <= 2'h0;
    else if (up_cnt_reg != 2'h3) up_cnt_reg <= up_cnt_reg + 2'h1;
  end

  a_four_wire_follow: assert property (up_cnt_reg == 2'h3 |->
    control_four_wire == $past(protocol_select_pin, 3)) else $error("four wire");
  a_regulator_follow: assert property (up_cnt_reg >= 2'h2 |->
    regulator_enable == $past(regulator_select_pin, 2)) else $error("regulator");
  a_cfg_load_plain: assert property (cfg_write && cfg_in.ref_src == REF_MCLK
    && cfg_in.sec_sig != 2'h3 |=> cfg_state == $past(cfg_in)) else $error("cfg load");
  a_cfg_hold_idle: assert property (!cfg_write |=> $stable(cfg_state))
    else $error("cfg hold");
  a_gpo1_drive: assert property ($past(cfg_state.gpio_fn) == GPIO_FN_GPO |->
    !gpio_pin_oe_n && gpio_pin_out == $past(core_out.gpo1)) else $error("gpo1");
  a_gpo2_drive: assert property ($past(cfg_state.dout_fn) == DOUT_FN_GPO |->
    !dout_pin_oe_n && dout_pin_out == $past(core_out.gpo2)) else $error("gpo2");
  a_gpio_off_idle: assert property ($past(cfg_state.gpio_fn) == GPIO_FN_OFF |->
    gpio_pin_oe_n && !gpio_pin_out) else $error("gpio idle");
  a_bclk_out_excl: assert property ($past(cfg_state.bclk_is_out) |->
    ##0 !bclk_pin_oe_n ##0 core_in.bclk == 1'b0) else $error("bclk out");
  a_bclk_shared: assert property (up_cnt_reg == 2'h3 && $past(cfg_state.ref_src) == REF_BCLK
    && !$past(cfg_state.bclk_is_out) |-> core_in.pll_ref == $past(bclk_pin_in, 3)
    && core_in.codec_clk == core_in.pll_ref && core_in.bclk == core_in.pll_ref)
    else $error("bclk shared");
  a_gpi1_route: assert property (up_cnt_reg == 2'h3 |-> core_in.gpi1 ==
    ($past(cfg_state.din_is_gpi) && $past(din_pin, 3))) else $error("gpi1");
  a_gpi3_route: assert property (up_cnt_reg == 2'h3 |-> core_in.gpi3 ==
    ($past(cfg_state.sclk_fn) == SCLK_FN_GPI && $past(sclk_pin, 3))) else $error("gpi3");
endmodule

bind multifunction_pin_allocator pin_alloc_sva chk_u (.*);

// >>> test/pin_host_model.sv
module pin_host_model (
  input wire logic [5:0] lvl,
  input wire logic       bclk_pin_out,
  input wire logic       bclk_pin_oe_n,
  input wire logic       wclk_pin_out,
  input wire logic       wclk_pin_oe_n,
  input wire logic       gpio_pin_out,
  input wire logic       gpio_pin_oe_n,
  output logic           mclk_pin,
  output logic           bclk_pin_in,
  output logic           wclk_pin_in,
  output logic           din_pin,
  output logic           gpio_pin_in,
  output logic           sclk_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // Shared wires show the device's value while its enable is low
  assign mclk_pin    = lvl[5];
  assign bclk_pin_in = bclk_pin_oe_n ? lvl[4] : bclk_pin_out;
  assign wclk_pin_in = wclk_pin_oe_n ? lvl[3] : wclk_pin_out;
  assign din_pin     = lvl[2];
  assign gpio_pin_in = gpio_pin_oe_n ? lvl[1] : gpio_pin_out;
  assign sclk_pin    = lvl[0];
endmodule

// >>> test/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import pin_alloc_pkg::*;
  logic      clock = 1'b0;
  logic      nrst = 1'b0;
  pin_cfg_s  cfg_in = CFG_RESET;
  pin_cfg_s  c;
  logic      cfg_write = 1'b0;
  logic      regulator_select_pin = 1'b0;
  logic      protocol_select_pin = 1'b0;
  core_out_s core_out = '0;
  logic [5:0] lvl = 6'h00;
  logic      mclk_pin, bclk_pin_in, wclk_pin_in, din_pin, gpio_pin_in, sclk_pin;
  logic      bclk_pin_out, bclk_pin_oe_n, wclk_pin_out, wclk_pin_oe_n;
  logic      gpio_pin_out, gpio_pin_oe_n, dout_pin_out, dout_pin_oe_n;
  core_in_s  core_in;
  pin_cfg_s  cfg_state;
  logic      control_four_wire, regulator_enable;
  int        errors = 0;
  int        checks = 0;
  logic [5:0] sel [4] = '{6'h20, 6'h10, 6'h04, 6'h02};
  logic [2:0] ex [4] = '{3'h6, 3'h7, 3'h4, 3'h6};

  multifunction_pin_allocator dut_u (.*);
  pin_host_model host_u (.*);

  always #20 clock = ~clock;

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report;
    if (errors == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic put_cfg(input pin_cfg_s v);
    cfg_in <= v;
    cfg_write <= 1'b1;
    @(posedge clock);
    cfg_write <= 1'b0;
    repeat (4) @(posedge clock);
  endtask

  // Three sync and register stages plus margin
  task automatic pins(input logic [5:0] v);
    lvl <= v;
    repeat (4) @(posedge clock);
  endtask

  initial begin
    repeat (5) @(posedge clock);
    check(16'(cfg_state), 16'(CFG_RESET));
    check(16'({bclk_pin_oe_n, wclk_pin_oe_n, gpio_pin_oe_n, dout_pin_oe_n}),
          16'h000F);
    nrst <= 1'b1;
    pins(6'h3C);
    check(16'(core_in), 16'h07C0);
    protocol_select_pin <= 1'b1;
    regulator_select_pin <= 1'b1;
    pins(6'h00);
    check(16'({control_four_wire, regulator_enable}), 16'h0003);
    c = '{REF_GPIO, 1'b1, 1'b0, 1'b0, GPIO_FN_GPO, DOUT_FN_OFF, SCLK_FN_OFF, 2'h3};
    put_cfg(c);
    check(16'({control_four_wire, regulator_enable}), 16'h0003);
    check(16'(cfg_state.gpio_fn), 16'(GPIO_FN_OFF));
    check(16'(cfg_state.sec_sig), 16'(SEC_SIG_BCLK));
    protocol_select_pin <= 1'b0;
    pins(6'h00);
    check(16'({control_four_wire, regulator_enable}), 16'h0001);
    for (int i = 0; i < 4; i++) begin
      c = CFG_RESET;
      c.ref_src = i[1:0];
      put_cfg(c);
      pins(sel[i]);
      check(16'({core_in.pll_ref, core_in.codec_clk, core_in.bclk}), 16'(ex[i]));
    end
    c = CFG_RESET;
    c.gpio_fn = GPIO_FN_GPO;
    c.dout_fn = DOUT_FN_GPO;
    c.bclk_is_out = 1'b1;
    core_out <= 10'h2C0;
    put_cfg(c);
    pins(6'h10);
    check(16'({bclk_pin_out, bclk_pin_oe_n, gpio_pin_out, gpio_pin_oe_n, dout_pin_out,
               dout_pin_oe_n, core_in.bclk}), 16'h0054);
    core_out <= 10'h030;
    pins(6'h10);
    check(16'({bclk_pin_out, gpio_pin_out, dout_pin_out, gpio_pin_oe_n}), 16'h0000);
    c.gpio_fn = GPIO_FN_FIRST_INTERRUPT_OUTPUT;
    c.dout_fn = DOUT_FN_SECOND_INTERRUPT_OUTPUT;
    put_cfg(c);
    check(16'({gpio_pin_out, dout_pin_out}), 16'h0003);
    c = CFG_RESET;
    c.din_is_gpi = 1'b1;
    c.gpio_fn = GPIO_FN_GPI;
    c.sclk_fn = SCLK_FN_GPI;
    put_cfg(c);
    pins(6'h07);
    check(16'({core_in.din, core_in.gpi1, core_in.gpi2, core_in.gpi3, gpio_pin_oe_n}),
          16'h000F);
    // Word clock driven out, secondary word clock taken from the serial clock pin
    c = CFG_RESET;
    c.wclk_is_out = 1'b1;
    c.sclk_fn = SCLK_FN_SEC_IN;
    c.sec_sig = SEC_SIG_WCLK;
    c.gpio_fn = GPIO_FN_AUX_CLK;
    c.dout_fn = DOUT_FN_SEC_WCLKO;
    core_out <= 10'h105;
    put_cfg(c);
    pins(6'h09);
    check(16'({wclk_pin_out, wclk_pin_oe_n, core_in.wclk, core_in.sec_bclk, core_in.sec_wclk,
               core_in.sec_din, core_in.gpi3, gpio_pin_out, dout_pin_out}),
          16'h0113);
    // Data pin taken by the multiplier refuses its input use; gpio pin wins the secondary
    c = CFG_RESET;
    c.ref_src = REF_DIN;
    c.din_is_gpi = 1'b1;
    c.gpio_fn = GPIO_FN_SEC_IN;
    c.sclk_fn = SCLK_FN_SEC_IN;
    c.sec_sig = SEC_SIG_DIN;
    c.dout_fn = DOUT_FN_SEC_DOUT;
    core_out <= 10'h002;
    put_cfg(c);
    pins(6'h06);
    check(16'({cfg_state.din_is_gpi, core_in.pll_ref, core_in.din, core_in.gpi1,
               core_in.sec_din, dout_pin_out, gpio_pin_oe_n}), 16'h0027);
    final_report();
  end

  initial begin
    repeat (2000) @(posedge clock);
    errors++;
    final_report();
  end
endmodule
